/* common/rsdc_pkg.sv */
/*
  package of the receiver status and demux config register bank:
  register addresses, field positions, reset value, states, helpers.
  assumes a serial-bus slave with 8-bit registers and 8-bit addresses.
*/
package rsdc_pkg;
  // register addresses and demux_config reset value
  localparam logic [7:0] REG_EVENT = 8'h00;
  localparam logic [7:0] REG_LIVE  = 8'h01;
  localparam logic [7:0] REG_CFG   = 8'ha8;
  localparam logic [7:0] CFG_RESET = 8'h0b;
  // demux_config fields
  localparam int CFG_RATIO_LO  = 0;
  localparam int CFG_RATIO_HI  = 1;
  localparam int CFG_RATIO_SRC = 2;
  localparam int CFG_COMPLEMENT_HEADER_CHECK      = 3;
  localparam int CFG_REV       = 4;
  localparam int CFG_MUTE      = 5;
  localparam int CFG_BA        = 6;
  localparam int CFG_BA_SRC    = 7;
  // event_flags and live_condition fields
  localparam int BIT_SIGNAL_LOST_CH_ONE = 0;
  localparam int BIT_SIGNAL_LOST_CH_TWO = 1;
  localparam int BIT_LOCK = 2;
  localparam int BIT_LIM  = 3;
  localparam int BIT_TEMP = 4;
  localparam logic [2:0] RSVD_ZERO = 3'h0;
  // ratio codes, bus bit counts and pointer step
  localparam logic [1:0] RATIO_16 = 2'h3;
  localparam logic [1:0] RATIO_10 = 2'h2;
  localparam logic [1:0] RATIO_8  = 2'h1;
  localparam logic [1:0] RATIO_4  = 2'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [7:0] PTR_STEP  = 8'h01;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_DEV  = 7'b0000010,
    ST_REG  = 7'b0000100,
    ST_WR   = 7'b0001000,
    ST_ACK  = 7'b0010000,
    ST_RD   = 7'b0100000,
    ST_MACK = 7'b1000000
  } rsdc_state_t;

  // parallel lanes in use for a ratio code
  function automatic logic [15:0] rsdc_lane_mask(input logic [1:0] ratio);
    unique case (ratio)
      RATIO_16: rsdc_lane_mask = 16'hffff;
      RATIO_10: rsdc_lane_mask = 16'h03ff;
      RATIO_8:  rsdc_lane_mask = 16'h00ff;
      RATIO_4:  rsdc_lane_mask = 16'h000f;
    endcase
  endfunction

  function automatic logic [15:0] rsdc_reverse(input logic [15:0] d);
    for (int i = 0; i < 16; i++) begin
      rsdc_reverse[i] = d[15-i];
    end
  endfunction
endpackage

/* design/rsdc_par_out.sv */
/*
  parallel output stage: lane masking by ratio, bit reversal and mute.
  assumes the settings arrive registered from the register bank.
*/
`timescale 1ns/1ps
module rsdc_par_out
  import rsdc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // settings
  input  wire logic [1:0]  demux_ratio_in,
  input  wire logic        bus_bit_reverse_in,
  input  wire logic        parallel_out_mute_in,
  // data
  input  wire logic [15:0] par_data_in,
  output logic      [15:0] par_data_out
);
  typedef struct packed {
    logic [15:0] data;
  } rsdc_po_t;

  rsdc_po_t st;
  rsdc_po_t next_st;

  // mask first so reversal moves lane 0 data onto lane 15
  always_comb begin
    logic [15:0] m;
    m = par_data_in & rsdc_lane_mask(demux_ratio_in);
    next_st.data = bus_bit_reverse_in ? rsdc_reverse(m) : m;
    if (parallel_out_mute_in) begin
      next_st.data = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign par_data_out = st.data;
endmodule

/* design/rsdc_regbank.sv */
/*
  register bank of the receiver: serial-bus slave, read-only event_flags
  and live_condition, write-only demux_config, and its derived controls.
  assumes scl/sda/cs are already synchronous to clk_in and slow vs 40 MHz.
*/
//Contract
//- event bit 0 reads channel one loss of signal.
//- event bit 1 reads channel two loss of signal.
//- event bit 2 reads 1 when frequency is outside lock window.
//- event bit 3 reads 1 when limiter auto-switching is enabled.
//- event bit 4 reads the over-temperature alarm.
//- status bits 0 and 1 read loss of signal on both channels.
//- status bit 2 reads 1 when frequency is inside lock window.
//- status bit 3 reads 1 for limiter one active, 0 for two.
//- status bit 4 reads the over-temperature alarm.
//- ratio from config bits 1:0 if bit 2 set, else from ratio pins.
//- config bit 3 adds complement header matching in 1:10 mode.
//- config bit 4 reverses the parallel output bus.
//- config bit 5 forces all parallel outputs to zero.
//- demux_config resets to 0x0b.
//- serial bus active only with chip select and control-mode pin high.
//- status registers read-only, config write-only.
`timescale 1ns/1ps
module rsdc_regbank
  import rsdc_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h5a // arbitrary bus address
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // serial bus
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        cs_in,
  input  wire logic        control_mode_pin_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // receiver conditions
  input  wire logic        signal_lost_ch_one_in,
  input  wire logic        signal_lost_ch_two_in,
  input  wire logic        freq_lock_window_in,
  input  wire logic        limiter_auto_switch_in,
  input  wire logic        active_limiter_in,
  input  wire logic        overtemp_alarm_in,
  // configuration pins
  input  wire logic        ratio_pin_low_in,
  input  wire logic        ratio_pin_high_in,
  input  wire logic        byte_align_pin_in,
  // derived controls
  output logic [1:0]       demux_ratio_out,
  output logic             complement_header_check_out,
  output logic             byte_align_enable_out,
  // parallel data
  input  wire logic [15:0] par_data_in,
  output logic      [15:0] par_data_out
);
  typedef struct packed {
    rsdc_state_t fsm;
    rsdc_state_t after;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic [7:0]  tx;
    logic        mack;
    logic        oe;
    logic [7:0]  cfg;
    logic [1:0]  ratio;
    logic        complement_header_check;
    logic        ba;
  } rsdc_regs_t;

  rsdc_regs_t st;
  rsdc_regs_t next_st;
  logic       ld;
  logic [7:0] ev_v;
  logic [7:0] live_v;
  logic [7:0] rd_v;

  // bus engine and register updates
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic sel;
    next_st = st;
    ld = 1'b0;
    next_st.scl_q = scl_in;
    next_st.sda_q = sda_in;
    rise  = scl_in & ~st.scl_q;
    fall  = ~scl_in & st.scl_q;
    start = scl_in & st.scl_q & st.sda_q & ~sda_in;
    stop  = scl_in & st.scl_q & ~st.sda_q & sda_in;
    sel   = cs_in & control_mode_pin_in;
    // read values; reserved top bits fixed at zero
    ev_v = {RSVD_ZERO, overtemp_alarm_in, limiter_auto_switch_in,
            ~freq_lock_window_in, signal_lost_ch_two_in, signal_lost_ch_one_in};
    live_v = {RSVD_ZERO, overtemp_alarm_in, active_limiter_in,
              freq_lock_window_in, signal_lost_ch_two_in, signal_lost_ch_one_in};
    // write-only config reads back zero rather than its contents
    rd_v = (st.ptr == REG_EVENT) ? ev_v : (st.ptr == REG_LIVE) ? live_v : '0;
    if (!sel) begin
      next_st.fsm = ST_IDLE;
      next_st.oe  = 1'b0;
    end else if (start) begin
      next_st.fsm = ST_DEV;
      next_st.cnt = '0;
      next_st.oe  = 1'b0;
    end else if (stop) begin
      next_st.fsm = ST_IDLE;
      next_st.oe  = 1'b0;
    end else begin
      unique case (st.fsm)
        ST_IDLE: begin
        end
        ST_DEV, ST_REG, ST_WR: begin
          if (rise) begin
            next_st.sh  = {st.sh[6:0], sda_in};
            next_st.cnt = st.cnt + 4'h1;
          end else if (fall && st.cnt == BYTE_BITS) begin
            next_st.cnt = '0;
            next_st.oe  = 1'b1;
            next_st.fsm = ST_ACK;
            next_st.after = ST_WR;
            if (st.fsm == ST_DEV) begin
              next_st.after = st.sh[0] ? ST_RD : ST_REG;
              if (st.sh[7:1] != SLAVE_ADDR) begin
                next_st.oe  = 1'b0;
                next_st.fsm = ST_IDLE;
              end
            end else if (st.fsm == ST_REG) begin
              next_st.ptr = st.sh;
            end else begin
              // only demux_config takes writes here
              if (st.ptr == REG_CFG) begin
                next_st.cfg = st.sh;
              end
              next_st.ptr = st.ptr + PTR_STEP;
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            next_st.oe  = 1'b0;
            next_st.fsm = st.after;
            if (st.after == ST_RD) begin
              ld = 1'b1;
              next_st.tx  = rd_v;
              next_st.oe  = ~rd_v[7];
              next_st.cnt = '0;
              next_st.ptr = st.ptr + PTR_STEP;
            end
          end
        end
        ST_RD: begin
          if (fall) begin
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == LAST_BIT) begin
              next_st.oe  = 1'b0;
              next_st.fsm = ST_MACK;
            end else begin
              next_st.tx = {st.tx[6:0], 1'b0};
              next_st.oe = ~st.tx[6];
            end
          end
        end
        ST_MACK: begin
          if (rise) begin
            next_st.mack = ~sda_in;
          end else if (fall) begin
            // a not-acknowledge ends the read burst
            if (st.mack) begin
              ld = 1'b1;
              next_st.fsm = ST_RD;
              next_st.tx  = rd_v;
              next_st.oe  = ~rd_v[7];
              next_st.cnt = '0;
              next_st.ptr = st.ptr + PTR_STEP;
            end else begin
              next_st.fsm = ST_IDLE;
            end
          end
        end
      endcase
    end
    // derived controls, one cycle behind demux_config
    next_st.ratio = st.cfg[CFG_RATIO_SRC] ? st.cfg[CFG_RATIO_HI:CFG_RATIO_LO]
                                          : {ratio_pin_high_in, ratio_pin_low_in};
    next_st.complement_header_check = st.cfg[CFG_COMPLEMENT_HEADER_CHECK];
    next_st.ba   = st.cfg[CFG_BA_SRC] ? st.cfg[CFG_BA] : byte_align_pin_in;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st       <= '0;
      st.fsm   <= ST_IDLE;
      st.after <= ST_IDLE;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.cfg   <= CFG_RESET;
      st.ratio <= RATIO_16;
    end else begin
      st <= next_st;
    end
  end

  // open drain: the pad only ever pulls low
  assign sda_out                     = 1'b0;
  assign sda_oe_out                  = st.oe;
  assign demux_ratio_out             = st.ratio;
  assign complement_header_check_out = st.complement_header_check;
  assign byte_align_enable_out       = st.ba;

  rsdc_par_out u_par_out (
    .clk_in               (clk_in),
    .sys_rst_in           (sys_rst_in),
    .demux_ratio_in       (st.ratio),
    .bus_bit_reverse_in   (st.cfg[CFG_REV]),
    .parallel_out_mute_in (st.cfg[CFG_MUTE]),
    .par_data_in          (par_data_in),
    .par_data_out         (par_data_out)
  );

  // checks on read values at the moment a byte is loaded, then on config reset, ratio, output stage and bus
  property p_ev_los;
    @(posedge clk_in) disable iff (sys_rst_in)
    ld && st.ptr == REG_EVENT |=> st.tx[1:0] == {$past(signal_lost_ch_two_in),
                                                  $past(signal_lost_ch_one_in)};
  endproperty
  a_ev_los: assert property (p_ev_los) else $error("event loss bits wrong");
  property p_ev_lock;
    @(posedge clk_in) disable iff (sys_rst_in)
    ld && st.ptr == REG_EVENT |=> st.tx[BIT_LOCK] != $past(freq_lock_window_in);
  endproperty
  a_ev_lock: assert property (p_ev_lock) else $error("event lock polarity wrong");
  property p_ev_sw_temp;
    @(posedge clk_in) disable iff (sys_rst_in)
    ld && st.ptr == REG_EVENT |=> st.tx[BIT_LIM] == $past(limiter_auto_switch_in)
                                  && st.tx[BIT_TEMP] == $past(overtemp_alarm_in);
  endproperty
  a_ev_sw_temp: assert property (p_ev_sw_temp) else $error("event bits 3/4 wrong");
  property p_live;
    @(posedge clk_in) disable iff (sys_rst_in)
    ld && st.ptr == REG_LIVE |=> st.tx[BIT_SIGNAL_LOST_CH_TWO:BIT_SIGNAL_LOST_CH_ONE] == {$past(signal_lost_ch_two_in),
      $past(signal_lost_ch_one_in)} && st.tx[BIT_LOCK] == $past(freq_lock_window_in);
  endproperty
  a_live: assert property (p_live) else $error("status bits 0..2 wrong");
  property p_live_hi;
    @(posedge clk_in) disable iff (sys_rst_in)
    ld && st.ptr == REG_LIVE |=> st.tx[BIT_LIM] == $past(active_limiter_in)
                                 && st.tx[BIT_TEMP] == $past(overtemp_alarm_in);
  endproperty
  a_live_hi: assert property (p_live_hi) else $error("status bits 3/4 wrong");
  property p_rsvd;
    @(posedge clk_in) disable iff (sys_rst_in)
    ld |=> st.tx[7:5] == RSVD_ZERO;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_cfg_reset;
    @(posedge clk_in) sys_rst_in |=> st.cfg == CFG_RESET && demux_ratio_out == RATIO_16;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong");
  property p_ratio;
    @(posedge clk_in) disable iff (sys_rst_in)
    !st.cfg[CFG_RATIO_SRC] ##1 !st.cfg[CFG_RATIO_SRC]
    |=> demux_ratio_out == {$past(ratio_pin_high_in), $past(ratio_pin_low_in)};
  endproperty
  a_ratio: assert property (p_ratio) else $error("pin ratio not followed");
  property p_mute;
    @(posedge clk_in) disable iff (sys_rst_in)
    st.cfg[CFG_MUTE] |=> par_data_out == '0;
  endproperty
  a_mute: assert property (p_mute) else $error("mute not applied");
  property p_rev;
    @(posedge clk_in) disable iff (sys_rst_in)
    !st.cfg[CFG_MUTE] && st.cfg[CFG_REV] && st.ratio == RATIO_16
    |=> par_data_out == rsdc_reverse($past(par_data_in));
  endproperty
  a_rev: assert property (p_rev) else $error("bus reversal wrong");
  property p_desel;
    @(posedge clk_in) disable iff (sys_rst_in)
    !(cs_in && control_mode_pin_in) |=> !sda_oe_out && st.fsm == ST_IDLE;
  endproperty
  a_desel: assert property (p_desel) else $error("bus active while deselected");
  property p_ro;
    @(posedge clk_in) disable iff (sys_rst_in)
    st.fsm == ST_WR && st.ptr != REG_CFG |=> $stable(st.cfg);
  endproperty
  a_ro: assert property (p_ro) else $error("config changed by other address");

  c_cfg_write: cover property (@(posedge clk_in) st.fsm == ST_WR ##1 $changed(st.cfg));
  c_ev_read: cover property (@(posedge clk_in) ld && st.ptr == REG_EVENT);
  c_burst: cover property (@(posedge clk_in) st.fsm == ST_MACK ##1 st.fsm == ST_RD);
endmodule

/* test/rsdc_bus_master.sv */
/*
  serial-bus master model that drives scl and its side of the sda wire.
  assumes the bench forms the wire with a pull-up: master level and not device pull.
*/
`timescale 1ns/1ps
module rsdc_bus_master (
  // clock
  input  wire logic clk_in,
  // bus
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  // bus idles released, both lines high
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // phases of 4 clk, above the 3 clk minimum
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // start also serves as repeated start from scl low
  task automatic start_cond();
    sda_out <= 1'b1;
    hold(4);
    scl_out <= 1'b1;
    hold(4);
    sda_out <= 1'b0;
    hold(4);
    scl_out <= 1'b0;
    hold(4);
  endtask
  task automatic stop_cond();
    sda_out <= 1'b0;
    hold(4);
    scl_out <= 1'b1;
    hold(4);
    sda_out <= 1'b1;
    hold(4);
  endtask
  // data moves while scl low, wire sampled at end of high phase
  task automatic bit_xfer(input logic b, output logic s);
    sda_out <= b;
    hold(4);
    scl_out <= 1'b1;
    hold(4);
    s = sda_in;
    scl_out <= 1'b0;
    hold(1);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, nak);
  endtask
  // status places are read back, and config once to check it reads zero
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      b[i] = s;
    end
    bit_xfer(last, s);
  endtask
endmodule

/* test/rsdc_regbank_bench.sv */
/*
  self-checking bench of the register bank, one task per scenario.
  assumes rsdc_bus_master as far side and a pull-up on the sda wire.
*/
`timescale 1ns/1ps
module rsdc_regbank_bench
  import rsdc_pkg::*;
;
  localparam logic [6:0] DEV = 7'h5a; // arbitrary bus address
  logic clk_in = 1'b0, sys_rst_in = 1'b1, cs = 1'b1, mode = 1'b1;
  logic signal_lost_ch_one = 1'b0, signal_lost_ch_two = 1'b0, lock = 1'b0, lsw = 1'b0, alim = 1'b0, temp = 1'b0;
  logic rp_lo = 1'b0, rp_hi = 1'b0, ba_pin = 1'b0;
  logic [15:0] par_in = 16'h00f3;
  logic scl, m_sda, dev_sda, sda_oe, complement_header_check, ba_en;
  logic [1:0] ratio;
  logic [15:0] par_out;
  logic sda_wire;
  int err_count = 0, checks_done = 0, cycles = 0;
  // open-drain wire, pulled up when nobody pulls low
  assign sda_wire = m_sda & ~sda_oe;
  always #12.5 clk_in = ~clk_in;
  rsdc_regbank #(.SLAVE_ADDR(DEV)) i_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_wire),
    .cs_in(cs), .control_mode_pin_in(mode), .sda_out(dev_sda), .sda_oe_out(sda_oe),
    .signal_lost_ch_one_in(signal_lost_ch_one), .signal_lost_ch_two_in(signal_lost_ch_two),
    .freq_lock_window_in(lock), .limiter_auto_switch_in(lsw),
    .active_limiter_in(alim), .overtemp_alarm_in(temp), .ratio_pin_low_in(rp_lo),
    .ratio_pin_high_in(rp_hi), .byte_align_pin_in(ba_pin), .demux_ratio_out(ratio),
    .complement_header_check_out(complement_header_check), .byte_align_enable_out(ba_en),
    .par_data_in(par_in), .par_data_out(par_out));
  rsdc_bus_master i_master (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
    .sda_out(m_sda));
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, well above the ~6.5k cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  // outputs are judged mid-cycle, after the pipeline has settled
  task automatic settle();
    i_master.hold(4);
    @(negedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic n0, n1, n2;
    i_master.start_cond();
    i_master.send_byte({DEV, 1'b0}, n0);
    i_master.send_byte(a, n1);
    i_master.send_byte(d, n2);
    i_master.stop_cond();
    nak = n0 | n1 | n2;
    settle();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic n0, n1, n2;
    i_master.start_cond();
    i_master.send_byte({DEV, 1'b0}, n0);
    i_master.send_byte(a, n1);
    i_master.start_cond();
    i_master.send_byte({DEV, 1'b1}, n2);
    i_master.recv_byte(1'b1, d);
    i_master.stop_cond();
    chk("read ack", 16'h0, {n0, n1, n2});
  endtask
  task automatic t_reset();
    ba_pin <= 1'b1;
    settle();
    // reset value takes the ratio from the pins, both low here
    chk("ratio", {14'h0, RATIO_4}, ratio);
    chk("complement_header_check", 16'h1, complement_header_check);
    chk("par", 16'h0003, par_out);
    chk("align", 16'h1, ba_en);
  endtask
  // vectors {alim, temp, lsw, lock, signal_lost_ch_two, signal_lost_ch_one}
  task automatic t_status();
    logic [5:0] vec [4] = '{6'h00, 6'h3f, 6'h15, 6'h2a};
    logic [7:0] d;
    foreach (vec[k]) begin
      {alim, temp, lsw, lock, signal_lost_ch_two, signal_lost_ch_one} <= vec[k];
      rd(REG_EVENT, d);
      chk("event", {8'h0, 3'h0, vec[k][4:3], ~vec[k][2], vec[k][1:0]}, d);
      rd(REG_LIVE, d);
      chk("live", {8'h0, 3'h0, vec[k][4], vec[k][5], vec[k][2:0]}, d);
    end
  endtask
  task automatic t_config();
    logic n;
    for (int c = 0; c < 4; c++) begin
      {rp_hi, rp_lo} <= ~c[1:0];
      wr(REG_CFG, {5'h01, 1'b1, c[1:0]}, n);
      chk("ratio reg", {14'h0, c[1:0]}, ratio);
      chk("par lanes", (c == 0) ? 16'h0003 : 16'h00f3, par_out);
      chk("complement_header_check on", 16'h1, complement_header_check);
    end
    wr(REG_CFG, 8'h08, n);
    for (int c = 0; c < 4; c++) begin
      {rp_hi, rp_lo} <= c[1:0];
      settle();
      chk("ratio pin", {14'h0, c[1:0]}, ratio);
    end
    // reversed, complement check off, ratio from pins (both high)
    wr(REG_CFG, 8'h13, n);
    chk("par rev", 16'hcf00, par_out);
    chk("complement_header_check off", 16'h0, complement_header_check);
    wr(REG_CFG, 8'h2b, n);
    chk("par mute", 16'h0, par_out);
    ba_pin <= 1'b0;
    wr(REG_CFG, 8'hcb, n);
    chk("align reg", 16'h1, ba_en);
    ba_pin <= 1'b1;
    wr(REG_CFG, 8'h8b, n);
    chk("align off", 16'h0, ba_en);
    chk("write ack", 16'h0, n);
  endtask
  task automatic t_refuse();
    logic n;
    logic [7:0] d;
    rd(REG_CFG, d);
    chk("cfg read", 16'h0, d);
    i_master.start_cond();
    i_master.send_byte(8'ha0, n);
    i_master.stop_cond();
    chk("foreign addr", 16'h1, n);
    // refused writes would move the ratio to 1:4 under register control
    cs <= 1'b0;
    wr(REG_CFG, 8'h0c, n);
    chk("cs low nak", 16'h1, n);
    cs <= 1'b1;
    mode <= 1'b0;
    wr(REG_CFG, 8'h0c, n);
    chk("mode low nak", 16'h1, n);
    mode <= 1'b1;
    chk("ratio kept", {14'h0, RATIO_16}, ratio);
  endtask
  // synchronous reset for 2 cycles, then the scenarios
  initial begin
    i_master.hold(2);
    sys_rst_in <= 1'b0;
    i_master.hold(2);
    t_reset();
    t_status();
    t_config();
    t_refuse();
    tally_and_finish();
  end
endmodule
